// ==== bench/sicb_config_bank_props.sv ====
/*
  Port checker for the configuration bank.
  Assumes I_POR is held at start; bound to the bank below.
*/
`timescale 1ns/1ps
module sicb_config_bank_props
  import sicb_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_POR,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire logic [15:0] I_IO_ADDR,
  input wire logic [7:0] I_IO_WDATA,
  input wire logic I_SER1_IRQ,
  input wire logic [7:0] O_IO_RDATA,
  input wire logic O_IO_RVALID,
  input wire logic O_CONFIG_MODE,
  input wire logic O_PP_EN,
  input wire logic [15:0] O_PP_BASE,
  input wire logic O_PP_PRINTER_MODE,
  input wire logic [1:0] O_PP_EXT_MODE,
  input wire logic O_CONFIG_ACCESS_PERMIT,
  input wire logic [15:0] O_SER1_BASE,
  input wire logic [7:0] O_FLOPPY_INTERFACE_OPTIONS,
  input wire logic O_SER1_IRQ_OE_N,
  input wire logic O_PARALLEL_INTERRUPT_OUT_O
);
  logic idx_wr;
  // Index port write decode
  assign idx_wr = I_IO_WR && I_IO_ADDR == SICB_INDEX_PORT;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_POR);
  // ****************************************************
  // Properties
  // ****************************************************
  a_por_defaults: assert property (disable iff (I_RST)
    $fell(I_POR) |-> O_PP_BASE == 16'h0278 && O_FLOPPY_INTERFACE_OPTIONS == 8'h78)
    else $error("defaults missing after power-up");
  a_lock_sticky: assert property (
    !O_CONFIG_ACCESS_PERMIT |=> !O_CONFIG_ACCESS_PERMIT)
    else $error("access permit returned");
  a_idle_frozen: assert property (
    !O_CONFIG_MODE |=> $stable(O_PP_BASE) && $stable(O_SER1_BASE) && $stable(O_FLOPPY_INTERFACE_OPTIONS))
    else $error("register changed outside config mode");
  a_mode_entry: assert property (
    $rose(O_CONFIG_MODE) |-> $past(idx_wr && I_IO_WDATA == SICB_KEY_ENTER))
    else $error("config mode entered without key");
  a_mode_exit: assert property (
    O_CONFIG_MODE && idx_wr && I_IO_WDATA == SICB_KEY_EXIT |=> !O_CONFIG_MODE)
    else $error("config mode kept after exit key");
  a_read_answer: assert property (
    I_IO_RD && I_IO_ADDR == SICB_DATA_PORT && O_CONFIG_MODE |=> O_IO_RVALID)
    else $error("data read not answered");
  a_locked_zero: assert property (
    O_IO_RVALID && !O_CONFIG_ACCESS_PERMIT |-> O_IO_RDATA == 8'h00)
    else $error("locked read returned data");
  a_irq_driven: assert property (
    $past(I_SER1_IRQ) && I_SER1_IRQ |-> !O_SER1_IRQ_OE_N)
    else $error("asserted interrupt not driven");
  a_par_forced: assert property (
    O_PP_EXT_MODE != 2'b00 |-> !O_PARALLEL_INTERRUPT_OUT_O)
    else $error("parallel interrupt driven high in extended mode");
  a_pp_decode: assert property (
    O_PP_EN == (O_PP_BASE != 16'h0000) && !(O_PP_PRINTER_MODE && O_PP_EXT_MODE != 2'b00))
    else $error("parallel decode inconsistent");
endmodule : sicb_config_bank_props

bind sicb_config_bank sicb_config_bank_props i_props (.*);

// ==== bench/sicb_host_model.sv ====
/*
  Host model issuing one-cycle I/O strobes to the bank.
  Assumes strobes are sampled on the rising clock edge.
*/
`timescale 1ns/1ps
module sicb_host_model
  import sicb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rvalid,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata
);
  // Bus idle at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 8'h00;
  end
  // One access; address and data scrambled once released
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc(1'b1, a, d);
  endtask : wr
  // Select then write; caller owns the reserved bit
  task automatic reg_wr(input logic [3:0] i, input logic [7:0] d);
    wr(SICB_INDEX_PORT, {4'h0, i});
    wr(SICB_DATA_PORT, d);
  endtask : reg_wr
  // Select then read; answer taken the cycle after the strobe
  task automatic reg_rd(input logic [3:0] i, output logic v, output logic [7:0] q);
    wr(SICB_INDEX_PORT, {4'h0, i});
    cyc(1'b0, SICB_DATA_PORT, 8'h00);
    v = i_rvalid;
    q = i_rdata;
  endtask : reg_rd
  // Unlock and lock keys
  task automatic enter();
    wr(SICB_INDEX_PORT, SICB_KEY_ENTER);
    wr(SICB_INDEX_PORT, SICB_KEY_ENTER);
  endtask : enter
  task automatic leave();
    wr(SICB_INDEX_PORT, SICB_KEY_EXIT);
  endtask : leave
endmodule : sicb_host_model

// ==== bench/tb_top.sv ====
/*
  Self-checking bench for the configuration bank.
  Assumes the host model and checker from bench/.
*/
`timescale 1ns/1ps
module tb_top
  import sicb_pkg::*;
;
  logic I_CLK, I_RST, I_POR, I_IO_WR, I_IO_RD, I_POWER_GOOD_INPUT;
  logic I_SER1_IRQ, I_SER2_IRQ, I_FLOPPY_IRQ, I_PAR_IRQ, v;
  logic [15:0] I_IO_ADDR, O_PP_BASE, O_SER1_BASE, O_SER2_BASE;
  logic [7:0] I_IO_WDATA, O_IO_RDATA, O_FLOPPY_INTERFACE_OPTIONS, q;
  logic [1:0] O_PP_EXT_MODE;
  logic O_IO_RVALID, O_CONFIG_MODE, O_DISK_EN, O_DISK_AT, O_FLOPPY_POWER_BIT, O_FLOPPY_ENABLE_BIT;
  logic O_OSC_RUN, O_BAUD_CLOCK_GENERATOR_EN, O_CONFIG_VALID, O_PP_EN, O_PP_POWER, O_PP_PRINTER_MODE;
  logic O_CONFIG_ACCESS_PERMIT, O_SER1_EN, O_SER1_RUN, O_SER2_EN, O_SER2_RUN, O_SER1_IRQ_O, O_SER1_IRQ_OE_N;
  logic O_SER2_IRQ_O, O_SER2_IRQ_OE_N, O_FLOPPY_INTERRUPT_OUT_O, O_FLOPPY_INTERRUPT_OUT_OE_N;
  logic O_PARALLEL_INTERRUPT_OUT_O, O_PARALLEL_INTERRUPT_OUT_OE_N;
  logic [15:0] pp [4] = '{16'h0000, 16'h03BC, 16'h0378, 16'h0278};
  logic [15:0] c3 [4] = '{16'h0338, 16'h03E8, 16'h02E8, 16'h0220};
  logic [15:0] c4 [4] = '{16'h0238, 16'h02E8, 16'h02E0, 16'h0228};
  logic [7:0] dflt [4] = '{8'h3B, 8'h9F, 8'hDC, 8'h78};
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  // All interrupt requests follow one stimulus
  assign {I_SER2_IRQ, I_FLOPPY_IRQ, I_PAR_IRQ} = {3{I_SER1_IRQ}};
  sicb_config_bank i_dut (.*);
  sicb_host_model i_host (.i_clk(I_CLK), .i_rvalid(O_IO_RVALID), .i_rdata(O_IO_RDATA),
    .o_wr(I_IO_WR), .o_rd(I_IO_RD), .o_addr(I_IO_ADDR), .o_wdata(I_IO_WDATA));
  // ****************************************************
  // Clock, timeout, compare and verdict
  // ****************************************************
  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic idle();
    repeat (2) @(posedge I_CLK);
    #1;
  endtask : idle
  task automatic give_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    I_RST = 1'b1;
    I_POR = 1'b1;
    I_POWER_GOOD_INPUT = 1'b0;
    I_SER1_IRQ = 1'b0;
    repeat (20) @(posedge I_CLK);
    #1;
    I_RST = 1'b0;
    I_POR = 1'b0;
    // Power-up values on decoded outputs
    check(O_PP_BASE, 16'h0278);
    check(O_SER1_BASE, 16'h03F8);
    check(O_SER2_BASE, 16'h02F8);
    check(O_FLOPPY_INTERFACE_OPTIONS, 8'h78);
    check({O_CONFIG_VALID, O_FLOPPY_ENABLE_BIT, O_FLOPPY_POWER_BIT, O_DISK_AT, O_DISK_EN, O_OSC_RUN}, 6'h1E);
    check({O_SER2_RUN, O_SER2_EN, O_SER1_RUN, O_SER1_EN, O_PP_POWER, O_PP_PRINTER_MODE}, 6'h3F);
    // Data port dead outside config mode
    i_host.wr(SICB_DATA_PORT, 8'h00);
    i_host.cyc(1'b0, SICB_DATA_PORT, 8'h00);
    check({O_IO_RVALID, O_DISK_EN}, 2'b01);
    // Foreign write between keys blocks entry
    i_host.wr(SICB_INDEX_PORT, SICB_KEY_ENTER);
    i_host.wr(16'h0080, SICB_KEY_ENTER);
    i_host.wr(SICB_INDEX_PORT, SICB_KEY_ENTER);
    check(O_CONFIG_MODE, 1'b0);
    i_host.wr(SICB_INDEX_PORT, SICB_KEY_ENTER);
    check(O_CONFIG_MODE, 1'b1);
    for (int i = 0; i < 4; i++) begin
      i_host.reg_rd(4'(i), v, q);
      check({v, q}, {1'b1, dflt[i]});
    end
    // Oscillator codes against power-good
    for (int k = 0; k < 8; k++) begin
      I_POWER_GOOD_INPUT = k[2];
      i_host.reg_wr(SICB_IDX_FUNC, {1'b1, k[1:0], 5'b11111});
      check({O_OSC_RUN, O_BAUD_CLOCK_GENERATOR_EN}, (k[1:0] == 0 || (k[1] != k[0] && k[2])) ? 2'b11 : 2'b00);
    end
    i_host.reg_rd(SICB_IDX_FUNC, v, q);
    check(q, 8'hFB);
    check({O_CONFIG_VALID, O_FLOPPY_ENABLE_BIT, O_FLOPPY_POWER_BIT, O_DISK_AT, O_DISK_EN}, 5'h1F);
    i_host.reg_wr(SICB_IDX_FUNC, 8'h00);
    check({O_CONFIG_VALID, O_FLOPPY_ENABLE_BIT, O_FLOPPY_POWER_BIT, O_DISK_AT, O_DISK_EN}, 5'h00);
    // Parallel and third/fourth serial bases
    i_host.reg_wr(SICB_IDX_SER, 8'hFE);
    for (int k = 0; k < 4; k++) begin
      i_host.reg_wr(SICB_IDX_PAR, {1'b1, k[1:0], 3'b111, k[1:0]});
      check(O_PP_BASE, pp[k]);
      check(O_PP_EN, 16'(k != 0));
      check(O_SER1_BASE, c3[k]);
      check(O_SER2_BASE, c4[k]);
    end
    // Interrupt polarity and extended-mode override
    I_SER1_IRQ = 1'b1;
    idle();
    check({O_SER1_IRQ_O, O_SER1_IRQ_OE_N, O_PARALLEL_INTERRUPT_OUT_O}, 3'b101);
    i_host.reg_wr(SICB_IDX_PAR, 8'hEF);
    i_host.reg_wr(SICB_IDX_EXTPAR, 8'h01);
    idle();
    check({O_FLOPPY_INTERRUPT_OUT_O, O_FLOPPY_INTERRUPT_OUT_OE_N, O_PP_EXT_MODE}, 4'h0);
    I_SER1_IRQ = 1'b0;
    idle();
    check({O_SER2_IRQ_O, O_SER2_IRQ_OE_N}, 2'b01);
    i_host.reg_wr(SICB_IDX_PAR, 8'hF7);
    I_SER1_IRQ = 1'b1;
    idle();
    check({O_PP_EXT_MODE, O_PARALLEL_INTERRUPT_OUT_O, O_PARALLEL_INTERRUPT_OUT_OE_N, O_SER1_IRQ_O}, 5'h09);
    // Ordinary reset drops mode, keeps contents
    I_RST = 1'b1;
    idle();
    I_RST = 1'b0;
    check({O_CONFIG_MODE, O_PP_EXT_MODE}, 3'b001);
    check(O_SER1_BASE, 16'h0220);
    i_host.enter();
    i_host.leave();
    check(O_CONFIG_MODE, 1'b0);
    // Lock bit sticks until power-up reset
    i_host.enter();
    i_host.reg_wr(SICB_IDX_PAR, 8'h1C);
    i_host.reg_wr(SICB_IDX_PAR, 8'hFF);
    i_host.reg_rd(SICB_IDX_SER, v, q);
    check({O_CONFIG_ACCESS_PERMIT, v, q}, 10'h100);
    check(O_PP_BASE, 16'h0000);
    I_POR = 1'b1;
    idle();
    I_POR = 1'b0;
    check({O_CONFIG_ACCESS_PERMIT, O_CONFIG_MODE}, 2'b10);
    check(O_PP_BASE, 16'h0278);
    give_verdict();
  end
endmodule : tb_top

// ==== hw/sicb_config_bank.sv ====
/*
  Configuration bank of a legacy PC peripheral chip: index/data port access
  with key unlock, registers 0-3 and register 4 bits 1:0 decoded into control outputs.
  Assumes host I/O cycles are one-clock strobes synchronous to I_CLK and
  that I_POR is the power-up/hard reset; I_RST is the ordinary system reset.
*/
// Notes on behaviour
// - Power-up loads defaults; ordinary system reset leaves configuration untouched.
// - Register 0 at index 0 in config mode; default 3Bh or 2Bh by variant.
// - Reg0 bit0 disk decode enable, bit1 AT/XT select, bit2 written zero.
// - Reg0 bit3 powers floppy controller; clear means low power.
// - Reg0 bit4 enables floppy controller, default set for 3Bh, clear for 2Bh.
// - Reg0 bits6:5 oscillator and baud clock control: 00 on, 11 off, 01 and 10 gated by power-good.
// - Reg0 bit7 is a software flag, zero at power-up, driven out on O_CONFIG_VALID.
// - Register 1 at index 1 in config mode, default 9Fh.
// - Reg1 bits1:0 parallel base: off, 3BCh, 378h, 278h.
// - Reg1 bit2 powers the parallel port.
// - Reg1 bit3 printer mode; clear enables extended modes from register 4.
// - Reg1 bit4 interrupt polarity: high/low driven, or low/high-impedance.
// - ECP or EPP mode forces parallel interrupt low-active open style.
// - Reg1 bits6:5 pick third and fourth serial bases.
// - Reg1 bit7 permits register access; once cleared only hard reset restores.
// - Register 2 at index 2 in config mode, default DCh.
// - Reg2 bits1:0 primary serial base: 3F8h, 2F8h, third, fourth.
// - Reg2 bit2 primary serial enable, bit3 primary normal operation.
// - Reg2 bits5:4 secondary serial base, same coding, default 2F8h.
// - Reg2 bit6 secondary serial enable, bit7 secondary normal operation.
// - Register 3 at index 3 in config mode, default 78h.
// - Two back-to-back 55h index writes enter config mode.
// - AAh to index port in config mode leaves config mode.
// - Index write selects register 0-F, data port reads or writes it.
`timescale 1ns/1ps
module sicb_config_bank
  import sicb_pkg::*;
#(
  parameter bit SECOND_VARIANT = 1'b0
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_POR,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire logic [15:0] I_IO_ADDR,
  input wire logic [7:0] I_IO_WDATA,
  input wire logic I_POWER_GOOD_INPUT,
  input wire logic I_SER1_IRQ,
  input wire logic I_SER2_IRQ,
  input wire logic I_FLOPPY_IRQ,
  input wire logic I_PAR_IRQ,
  output logic [7:0] O_IO_RDATA,
  output logic O_IO_RVALID,
  output logic O_CONFIG_MODE,
  output logic O_DISK_EN,
  output logic O_DISK_AT,
  output logic O_FLOPPY_POWER_BIT,
  output logic O_FLOPPY_ENABLE_BIT,
  output logic O_OSC_RUN,
  output logic O_BAUD_CLOCK_GENERATOR_EN,
  output logic O_CONFIG_VALID,
  output logic O_PP_EN,
  output logic [15:0] O_PP_BASE,
  output logic O_PP_POWER,
  output logic O_PP_PRINTER_MODE,
  output logic [1:0] O_PP_EXT_MODE,
  output logic O_CONFIG_ACCESS_PERMIT,
  output logic O_SER1_EN,
  output logic O_SER1_RUN,
  output logic [15:0] O_SER1_BASE,
  output logic O_SER2_EN,
  output logic O_SER2_RUN,
  output logic [15:0] O_SER2_BASE,
  output logic [7:0] O_FLOPPY_INTERFACE_OPTIONS,
  output logic O_SER1_IRQ_O,
  output logic O_SER1_IRQ_OE_N,
  output logic O_SER2_IRQ_O,
  output logic O_SER2_IRQ_OE_N,
  output logic O_FLOPPY_INTERRUPT_OUT_O,
  output logic O_FLOPPY_INTERRUPT_OUT_OE_N,
  output logic O_PARALLEL_INTERRUPT_OUT_O,
  output logic O_PARALLEL_INTERRUPT_OUT_OE_N
);

  localparam logic [7:0] FUNC_DEFAULT = SECOND_VARIANT ? SICB_RST_FUNC_B : SICB_RST_FUNC_A;

  typedef struct packed {
    sicb_state_t state;
    logic [3:0] index;
    logic rvalid;
  } sicb_ctl_t;

  sicb_ctl_t st_reg;
  sicb_ctl_t st_next;
  logic [127:0] flat;
  logic [15:0][7:0] cfg;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic idx_wr;
  logic data_wr;
  logic data_rd;
  logic [7:0] r_func;
  logic [7:0] r_par;
  logic [7:0] r_ser;
  logic [1:0] ext_mode;
  logic ecp_or_epp;

  // ****************************************************
  // Helper functions
  // ****************************************************

  // Serial base decode shared by both ports
  function automatic logic [15:0] ser_base(input logic [1:0] sel, input logic [1:0] com34, input logic fourth);
    logic [15:0] c3;
    logic [15:0] c4;
    c3 = SICB_COM3_0;
    c4 = SICB_COM4_0;
    case (com34)
      2'b00: begin c3 = SICB_COM3_0; c4 = SICB_COM4_0; end
      2'b01: begin c3 = SICB_COM3_1; c4 = SICB_COM4_1; end
      2'b10: begin c3 = SICB_COM3_2; c4 = SICB_COM4_2; end
      default: begin c3 = SICB_COM3_3; c4 = SICB_COM4_3; end
    endcase
    case (sel)
      2'b00: ser_base = SICB_SER_BASE_0;
      2'b01: ser_base = SICB_SER_BASE_1;
      2'b10: ser_base = c3;
      default: ser_base = c4;
    endcase
    if (fourth) begin
      ser_base = c4;
    end
  endfunction : ser_base

  // Interrupt pin drive from polarity: value and active-low enable
  function automatic logic [1:0] irq_drive(input logic req, input logic active_high);
    if (active_high) begin
      irq_drive = {req, 1'b0};
    end else begin
      irq_drive = {1'b0, ~req};
    end
  endfunction : irq_drive

  // ****************************************************
  // Host port decode
  // ****************************************************
  assign idx_wr = I_IO_WR && (I_IO_ADDR == SICB_INDEX_PORT);
  assign data_wr = I_IO_WR && (I_IO_ADDR == SICB_DATA_PORT);
  assign data_rd = I_IO_RD && (I_IO_ADDR == SICB_DATA_PORT);

  // Config writes need mode and permit bit
  always_comb begin
    mem_we = data_wr && (st_reg.state == SICB_ST_CONFIG) && r_par[SICB_F_PERMIT];
    mem_wdata = I_IO_WDATA;
    if (st_reg.index == SICB_IDX_FUNC) begin
      mem_wdata[SICB_F_RESERVED_ZERO] = 1'b0;
    end
    if (st_reg.index == SICB_IDX_PAR && !r_par[SICB_F_PERMIT]) begin
      mem_wdata[SICB_F_PERMIT] = 1'b0;
    end
  end

  // ****************************************************
  // Unlock sequencer and index
  // ****************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    case (st_reg.state)
      SICB_ST_IDLE: begin
        if (idx_wr && I_IO_WDATA == SICB_KEY_ENTER) begin
          st_next.state = SICB_ST_KEY1;
        end
      end
      SICB_ST_KEY1: begin
        if (idx_wr && I_IO_WDATA == SICB_KEY_ENTER) begin
          st_next.state = SICB_ST_CONFIG;
        end else if (I_IO_WR) begin
          st_next.state = SICB_ST_IDLE;
        end
      end
      SICB_ST_CONFIG: begin
        if (idx_wr && I_IO_WDATA == SICB_KEY_EXIT) begin
          st_next.state = SICB_ST_IDLE;
        end else if (idx_wr) begin
          st_next.index = I_IO_WDATA[3:0];
        end
        if (data_rd) begin
          st_next.rvalid = 1'b1;
        end
      end
      default: begin
        st_next.state = SICB_ST_IDLE;
      end
    endcase
  end

  // Index reset only by power-up; system reset drops config mode
  always_ff @(posedge I_CLK) begin
    if (I_POR) begin
      st_reg <= '{state: SICB_ST_IDLE, index: 4'h0, rvalid: 1'b0};
    end else if (I_RST) begin
      st_reg <= '{state: SICB_ST_IDLE, index: st_reg.index, rvalid: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************
  // Register store, loaded only at power-up
  // ****************************************************
  sicb_regfile #(
    .FUNC_DEFAULT(FUNC_DEFAULT)
  ) u_store (
    .i_clk(I_CLK),
    .i_init(I_POR),
    .i_we(mem_we),
    .i_addr(st_reg.index),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata),
    .o_flat(flat)
  );

  assign cfg = flat;
  assign r_func = cfg[SICB_IDX_FUNC];
  assign r_par = cfg[SICB_IDX_PAR];
  assign r_ser = cfg[SICB_IDX_SER];
  assign ext_mode = cfg[SICB_IDX_EXTPAR][1:0];

  // Read data blanked when access is locked
  assign O_IO_RDATA = r_par[SICB_F_PERMIT] ? mem_rdata : 8'h00;
  assign O_IO_RVALID = st_reg.rvalid;
  assign O_CONFIG_MODE = (st_reg.state == SICB_ST_CONFIG);

  // ****************************************************
  // Function control decode
  // ****************************************************
  assign O_DISK_EN = r_func[SICB_F_DISK_EN];
  assign O_DISK_AT = r_func[SICB_F_DISK_AT];
  assign O_FLOPPY_POWER_BIT = r_func[SICB_F_FLOPPY_PWR];
  assign O_FLOPPY_ENABLE_BIT = r_func[SICB_F_FLOPPY_EN];
  assign O_CONFIG_VALID = r_func[SICB_F_VALID];

  // Oscillator and baud clock gating
  always_comb begin
    case (r_func[SICB_F_OSC_LO +: 2])
      2'b00: begin O_OSC_RUN = 1'b1; O_BAUD_CLOCK_GENERATOR_EN = 1'b1; end
      2'b11: begin O_OSC_RUN = 1'b0; O_BAUD_CLOCK_GENERATOR_EN = 1'b0; end
      default: begin
        O_OSC_RUN = I_POWER_GOOD_INPUT;
        O_BAUD_CLOCK_GENERATOR_EN = I_POWER_GOOD_INPUT;
      end
    endcase
  end

  // Parallel port decode
  always_comb begin
    O_PP_EN = (r_par[SICB_F_PP_BASE_LO +: 2] != 2'b00);
    case (r_par[SICB_F_PP_BASE_LO +: 2])
      2'b01: O_PP_BASE = SICB_PP_BASE_1;
      2'b10: O_PP_BASE = SICB_PP_BASE_2;
      2'b11: O_PP_BASE = SICB_PP_BASE_3;
      default: O_PP_BASE = 16'h0000;
    endcase
  end
  assign O_PP_POWER = r_par[SICB_F_PP_PWR];
  assign O_PP_PRINTER_MODE = r_par[SICB_F_PP_PRINTER];
  assign O_PP_EXT_MODE = r_par[SICB_F_PP_PRINTER] ? 2'b00 : ext_mode;
  assign ecp_or_epp = !r_par[SICB_F_PP_PRINTER] && (ext_mode != 2'b00);
  assign O_CONFIG_ACCESS_PERMIT = r_par[SICB_F_PERMIT];

  // Serial port decode
  assign O_SER1_BASE = ser_base(r_ser[SICB_F_SER1_BASE_LO +: 2], r_par[SICB_F_COM34_LO +: 2], 1'b0);
  assign O_SER2_BASE = ser_base(r_ser[SICB_F_SER2_BASE_LO +: 2], r_par[SICB_F_COM34_LO +: 2], 1'b0);
  assign O_SER1_EN = r_ser[SICB_F_SER1_EN];
  assign O_SER1_RUN = r_ser[SICB_F_SER1_RUN];
  assign O_SER2_EN = r_ser[SICB_F_SER2_EN];
  assign O_SER2_RUN = r_ser[SICB_F_SER2_RUN];
  assign O_FLOPPY_INTERFACE_OPTIONS = cfg[SICB_IDX_FLOPPY];

  // ****************************************************
  // Interrupt pin drivers
  // ****************************************************
  assign {O_SER1_IRQ_O, O_SER1_IRQ_OE_N} = irq_drive(I_SER1_IRQ, r_par[SICB_F_IRQ_POL]);
  assign {O_SER2_IRQ_O, O_SER2_IRQ_OE_N} = irq_drive(I_SER2_IRQ, r_par[SICB_F_IRQ_POL]);
  assign {O_FLOPPY_INTERRUPT_OUT_O, O_FLOPPY_INTERRUPT_OUT_OE_N} =
    irq_drive(I_FLOPPY_IRQ, r_par[SICB_F_IRQ_POL]);
  assign {O_PARALLEL_INTERRUPT_OUT_O, O_PARALLEL_INTERRUPT_OUT_OE_N} =
    irq_drive(I_PAR_IRQ, r_par[SICB_F_IRQ_POL] && !ecp_or_epp);

endmodule : sicb_config_bank

// ==== hw/sicb_regfile.sv ====
/*
  Sixteen-entry by 8-bit configuration store with registered read data.
  Assumes the caller gates writes; contents are loaded only by i_init.
*/
`timescale 1ns/1ps
module sicb_regfile
  import sicb_pkg::*;
#(
  parameter logic [7:0] FUNC_DEFAULT = SICB_RST_FUNC_A
) (
  input wire logic i_clk,
  input wire logic i_init,
  input wire logic i_we,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic [127:0] o_flat
);

  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [7:0] rdata;
  } sicb_mem_state_t;

  sicb_mem_state_t st_reg;
  sicb_mem_state_t st_next;

  // ****************************************************
  // Next state: power-up load, write, registered read
  // ****************************************************
  always_comb begin
    st_next = st_reg;
    if (i_init) begin
      for (int i = 0; i < 16; i++) begin
        st_next.mem[i] = SICB_RST_OTHER;
      end
      st_next.mem[SICB_IDX_FUNC] = FUNC_DEFAULT;
      st_next.mem[SICB_IDX_PAR] = SICB_RST_PAR;
      st_next.mem[SICB_IDX_SER] = SICB_RST_SER;
      st_next.mem[SICB_IDX_FLOPPY] = SICB_RST_FLOPPY;
      st_next.mem[SICB_IDX_EXTPAR] = SICB_RST_EXTPAR;
    end else if (i_we) begin
      st_next.mem[i_addr] = i_wdata;
    end
    st_next.rdata = st_next.mem[i_addr];
  end

  // State register
  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end

  assign o_rdata = st_reg.rdata;
  assign o_flat = st_reg.mem;

endmodule : sicb_regfile

// ==== include/sicb_pkg.sv ====
/*
  Package for the legacy peripheral configuration bank: port addresses,
  unlock/exit keys, register indices, field positions and power-up values.
  Assumes one 8-bit host I/O data path and 16-bit port addresses.
*/
package sicb_pkg;

  // ****************************************************
  // Host port addresses and key bytes
  // ****************************************************
  localparam logic [15:0] SICB_INDEX_PORT = 16'h03F0;
  localparam logic [15:0] SICB_DATA_PORT = 16'h03F1;
  localparam logic [7:0] SICB_KEY_ENTER = 8'h55;
  localparam logic [7:0] SICB_KEY_EXIT = 8'hAA;

  // ****************************************************
  // Register indices and power-up values
  // ****************************************************
  localparam logic [3:0] SICB_IDX_FUNC = 4'h0;
  localparam logic [3:0] SICB_IDX_PAR = 4'h1;
  localparam logic [3:0] SICB_IDX_SER = 4'h2;
  localparam logic [3:0] SICB_IDX_FLOPPY = 4'h3;
  localparam logic [3:0] SICB_IDX_EXTPAR = 4'h4;
  localparam logic [7:0] SICB_RST_FUNC_A = 8'h3B;
  localparam logic [7:0] SICB_RST_FUNC_B = 8'h2B;
  localparam logic [7:0] SICB_RST_PAR = 8'h9F;
  localparam logic [7:0] SICB_RST_SER = 8'hDC;
  localparam logic [7:0] SICB_RST_FLOPPY = 8'h78;
  localparam logic [7:0] SICB_RST_EXTPAR = 8'h00;
  localparam logic [7:0] SICB_RST_OTHER = 8'h00;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int SICB_F_DISK_EN = 0;
  localparam int SICB_F_DISK_AT = 1;
  localparam int SICB_F_RESERVED_ZERO = 2;
  localparam int SICB_F_FLOPPY_PWR = 3;
  localparam int SICB_F_FLOPPY_EN = 4;
  localparam int SICB_F_OSC_LO = 5;
  localparam int SICB_F_VALID = 7;
  localparam int SICB_F_PP_BASE_LO = 0;
  localparam int SICB_F_PP_PWR = 2;
  localparam int SICB_F_PP_PRINTER = 3;
  localparam int SICB_F_IRQ_POL = 4;
  localparam int SICB_F_COM34_LO = 5;
  localparam int SICB_F_PERMIT = 7;
  localparam int SICB_F_SER1_BASE_LO = 0;
  localparam int SICB_F_SER1_EN = 2;
  localparam int SICB_F_SER1_RUN = 3;
  localparam int SICB_F_SER2_BASE_LO = 4;
  localparam int SICB_F_SER2_EN = 6;
  localparam int SICB_F_SER2_RUN = 7;

  // ****************************************************
  // Decoded base addresses
  // ****************************************************
  localparam logic [15:0] SICB_PP_BASE_1 = 16'h03BC;
  localparam logic [15:0] SICB_PP_BASE_2 = 16'h0378;
  localparam logic [15:0] SICB_PP_BASE_3 = 16'h0278;
  localparam logic [15:0] SICB_SER_BASE_0 = 16'h03F8;
  localparam logic [15:0] SICB_SER_BASE_1 = 16'h02F8;
  localparam logic [15:0] SICB_COM3_0 = 16'h0338;
  localparam logic [15:0] SICB_COM4_0 = 16'h0238;
  localparam logic [15:0] SICB_COM3_1 = 16'h03E8;
  localparam logic [15:0] SICB_COM4_1 = 16'h02E8;
  localparam logic [15:0] SICB_COM3_2 = 16'h02E8;
  localparam logic [15:0] SICB_COM4_2 = 16'h02E0;
  localparam logic [15:0] SICB_COM3_3 = 16'h0220;
  localparam logic [15:0] SICB_COM4_3 = 16'h0228;

  // Unlock sequencer states
  typedef enum logic [2:0] {
    SICB_ST_IDLE = 3'b001,
    SICB_ST_KEY1 = 3'b010,
    SICB_ST_CONFIG = 3'b100
  } sicb_state_t;

endpackage : sicb_pkg
